// ==== aopm_map.svh ====
`ifndef AOPM_MAP_SVH
`define AOPM_MAP_SVH
// Register indices on the plain port
`define AOPM_REG_CONFIG      4'h0
`define AOPM_REG_STATUS      4'h1
`define AOPM_REG_RESULT      4'h2
`define AOPM_REG_LEVEL       4'h3
// Configuration word bit positions
`define AOPM_BIT_REFBUF      14
`define AOPM_BIT_CLKOUT      28
`define AOPM_BIT_EXTCLK      29
`define AOPM_CONFIG_RESET    32'h0000_0000
// Variant resolutions
`define AOPM_RES_12          2'h0
`define AOPM_RES_14          2'h1
`define AOPM_RES_16          2'h2
// Buffering
`define AOPM_FIFO_DEPTH      8
`define AOPM_FIFO_WIDTH      16
`define AOPM_SHIFT_BITS      5'h0_F
`endif

// ==== aopm_pkg.sv ====
package aopm_pkg;
  typedef enum logic [1:0] {
    AOPM_IDLE  = 2'b00,
    AOPM_SHIFT = 2'b01
  } aopm_state_type;

  typedef struct packed {
    logic configSourceSelect;
    logic interfaceSelect;
    logic refBufferDisablePin;
    logic pairBSelect;
    logic pairCdOutputSelect;
    logic rangePinIn;
  } aopm_pins_type;

  typedef struct packed {
    logic refBuffersOn;
    logic rangeWide;
    logic extConvClockSelect;
    logic convClockOutputEnable;
    logic serialMode;
  } aopm_mode_type;
endpackage

// ==== aopm_fifo.sv ====
`timescale 1ns/1ns
module aopm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic      [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (level != DEPTH[AW:0]);
  assign outValid = (level != '0);
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= AW'(wrPtr + 1'b1);
      end
      if (doRead) begin
        rdPtr <= AW'(rdPtr + 1'b1);
      end
      level <= (AW+1)'(level + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead});
    end
  end
endmodule

// ==== aopm_top.sv ====
// Function
// [R1] 12-bit variant: MSB on bus bit 11, bits 12..15 copy it.
// [R2] 14-bit variant: MSB on bus bit 13, bits 14..15 copy it.
// [R3] 16-bit variant: all sixteen bus bits, bit 15 is MSB.
// [R4] Pin control, serial: buffer pin low enables reference buffers, high disables.
// [R5] Software control: buffer pin ignored, configuration bit 14 controls buffers.
// [R6] First serial output carries A; plus C if CD select 0; all if B too.
// [R7] B select 1: second output carries B, plus D when CD select 0.
// [R8] Third and fourth outputs carry C and D only when CD select is 1.
// [R9] Source pin low: settings from pins; high: from configuration word.
// [R10] Interface pin low selects parallel, high selects serial.
// [R11] Pin control: range pin low gives four times reference, high twice.
// [R12] Software control: bit 29 takes external clock, bit 28 drives internal clock.
// [R13] Bus driven only while read strobe and chip select are low.
// [R14] B select low: second output disabled, all channels on first output when CD select is 0.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "aopm_map.svh"
module aopm_top
  import aopm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Mode pins
  input  wire aopm_pins_type pins,
  input  wire logic [1:0]  resolution,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // Conversion results, one channel word each
  input  wire logic        resultValid,
  output logic             resultReady,
  input  wire logic [2:0]  resultChannel,
  input  wire logic [15:0] resultData,
  // Parallel bus
  input  wire logic        readStrobe_n,
  input  wire logic        chipSelect_n,
  output logic      [15:0] parallelBusOut,
  output logic      [15:0] parallelBusOe_n,
  // Serial outputs
  input  wire logic        serialShiftClk,
  output logic             serial_out_first,
  output logic             serial_out_second,
  output logic             serial_out_third,
  output logic             serial_out_fourth,
  // Range pin and conversion clock
  input  wire logic        internalConvClock,
  output logic             rangePinOut,
  output logic             rangePinOe_n,
  output logic             convClock,
  // Resolved mode
  output aopm_mode_type    mode
);
  logic [31:0]      configWord;
  logic             softMode;
  logic             fifoValid;
  logic             fifoReady;
  logic [15:0]      fifoData;
  logic [3:0]       fifoLevel;
  logic [15:0]      extended;
  logic [15:0]      outWord;
  logic [2:0]       outChannel;
  logic [2:0]       chanQueue [8];
  logic [2:0]       chanWr;
  logic [2:0]       chanRd;
  logic [15:0]      shiftReg;
  logic [4:0]       bitCount;
  aopm_state_type   state;
  aopm_state_type   next_state;
  logic             busEnable;
  logic [1:0]       pairSel;
  logic             serialBit;
  logic             pullWord;

  aopm_fifo #(.WIDTH(`AOPM_FIFO_WIDTH), .DEPTH(`AOPM_FIFO_DEPTH)) resultFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (resultValid),
    .inReady  (resultReady),
    .inData   (resultData),
    .outValid (fifoValid),
    .outReady (fifoReady),
    .outData  (fifoData),
    .level    (fifoLevel)
  );

  // Channel tags ride beside the data in a twin queue
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chanWr <= '0;
      chanRd <= '0;
    end else begin
      if (resultValid && resultReady) begin
        chanQueue[chanWr] <= resultChannel;
        chanWr <= 3'(chanWr + 1'b1);
      end
      if (fifoValid && fifoReady) begin
        chanRd <= 3'(chanRd + 1'b1);
      end
    end
  end

  // Configuration word, written only over the register port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      configWord <= `AOPM_CONFIG_RESET;
    end else if (regWrite && regAddr == `AOPM_REG_CONFIG) begin
      configWord <= regWrData;
    end
  end

  // Mode resolution
  assign softMode = pins.configSourceSelect;                                 // [R9]
  always_comb begin
    mode.serialMode = pins.interfaceSelect;                                  // [R10]
    if (softMode) begin
      mode.refBuffersOn          = configWord[`AOPM_BIT_REFBUF];             // [R5]
      mode.rangeWide             = 1'b0;
      mode.extConvClockSelect    = configWord[`AOPM_BIT_EXTCLK];             // [R12]
      mode.convClockOutputEnable = configWord[`AOPM_BIT_CLKOUT];             // [R12]
    end else begin
      mode.refBuffersOn          = pins.interfaceSelect ? !pins.refBufferDisablePin : 1'b1; // [R4]
      mode.rangeWide             = !pins.rangePinIn;                         // [R11]
      mode.extConvClockSelect    = 1'b0;
      mode.convClockOutputEnable = 1'b0;
    end
  end

  // Range pin doubles as conversion clock in or out
  assign rangePinOut  = internalConvClock;
  assign rangePinOe_n = !(softMode && mode.convClockOutputEnable && !mode.extConvClockSelect); // [R12]
  assign convClock    = mode.extConvClockSelect ? pins.rangePinIn : internalConvClock; // [R12]

  // Sign extension by variant
  always_comb begin
    case (resolution)
      `AOPM_RES_12: extended = {{4{fifoData[11]}}, fifoData[11:0]};         // [R1]
      `AOPM_RES_14: extended = {{2{fifoData[13]}}, fifoData[13:0]};         // [R2]
      default:      extended = fifoData;                                     // [R3]
    endcase
  end

  // Parallel: a word is consumed per clock cycle with read strobe and chip select low; serial: per shift word
  assign busEnable = !mode.serialMode && !readStrobe_n && !chipSelect_n;     // [R13]
  assign pullWord  = mode.serialMode ? (state == AOPM_IDLE) : 1'b0;
  assign fifoReady = pullWord || (!mode.serialMode && busEnable && state == AOPM_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outWord    <= '0;
      outChannel <= '0;
    end else if (fifoValid && fifoReady) begin
      outWord    <= extended;
      outChannel <= chanQueue[chanRd];
    end
  end

  // Pair A=0..1, B=2..3, C=4..5, D=6..7
  assign pairSel = outChannel[2:1];

  always_comb begin
    case (state)
      AOPM_IDLE:  next_state = (fifoValid && mode.serialMode) ? AOPM_SHIFT : AOPM_IDLE;
      AOPM_SHIFT: next_state = (bitCount == `AOPM_SHIFT_BITS && serialShiftClk) ?
                               AOPM_IDLE : AOPM_SHIFT;
      default:    next_state = AOPM_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= AOPM_IDLE;
      bitCount <= '0;
      shiftReg <= '0;
    end else begin
      state <= next_state;
      if (state == AOPM_IDLE) begin
        bitCount <= '0;
        shiftReg <= extended;
      end else if (serialShiftClk) begin
        bitCount <= 5'(bitCount + 1'b1);
        shiftReg <= {shiftReg[14:0], 1'b0};
      end
    end
  end

  assign serialBit = (state == AOPM_SHIFT) ? shiftReg[15] : 1'b0;

  // Serial routing; parallel bus pins carry the word when not serial
  always_comb begin
    serial_out_first  = 1'b0;
    serial_out_second = 1'b0;
    serial_out_third  = 1'b0;
    serial_out_fourth = 1'b0;
    if (mode.serialMode) begin
      case (pairSel)
        2'b00: serial_out_first = serialBit;                                 // [R6]
        2'b01: begin
          if (pins.pairBSelect) begin
            serial_out_second = serialBit;                                   // [R7]
          end else begin
            serial_out_first = serialBit;                                    // [R14]
          end
        end
        2'b10: begin
          if (pins.pairCdOutputSelect) begin
            serial_out_third = serialBit;                                    // [R8]
          end else begin
            serial_out_first = serialBit;                                    // [R6]
          end
        end
        default: begin
          if (pins.pairCdOutputSelect) begin
            serial_out_fourth = serialBit;                                   // [R8]
          end else if (pins.pairBSelect) begin
            serial_out_second = serialBit;                                   // [R7]
          end else begin
            serial_out_first = serialBit;                                    // [R14]
          end
        end
      endcase
    end
  end

  assign parallelBusOut  = outWord;
  assign parallelBusOe_n = {16{!busEnable}};                                 // [R13]

  // Register reads answer one cycle later; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRead) begin
      case (regAddr)
        `AOPM_REG_CONFIG: regRdData <= configWord;
        `AOPM_REG_STATUS: regRdData <= {27'h000_0000, mode};
        `AOPM_REG_RESULT: regRdData <= {16'h0000, outWord};
        `AOPM_REG_LEVEL:  regRdData <= {28'h000_0000, fifoLevel};
        default:          regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // Checks
  sext12_a: assert property (@(posedge clk) disable iff (!rst_n)
    resolution == `AOPM_RES_12 |-> extended[15:12] == {4{extended[11]}})     // [R1]
    else $error("12-bit sign extension wrong");
  sext14_a: assert property (@(posedge clk) disable iff (!rst_n)
    resolution == `AOPM_RES_14 |-> extended[15:14] == {2{extended[13]}})     // [R2]
    else $error("14-bit sign extension wrong");
  full16_a: assert property (@(posedge clk) disable iff (!rst_n)
    resolution == `AOPM_RES_16 |-> extended == fifoData)                     // [R3]
    else $error("16-bit word altered");
  refbuf_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!softMode && pins.interfaceSelect) |-> mode.refBuffersOn == !pins.refBufferDisablePin) // [R4]
    else $error("buffer pin not obeyed");
  softbuf_a: assert property (@(posedge clk) disable iff (!rst_n)
    softMode |-> mode.refBuffersOn == configWord[14])                        // [R5]
    else $error("config buffer bit not obeyed");
  cd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.pairCdOutputSelect |-> !serial_out_third && !serial_out_fourth)    // [R8]
    else $error("third or fourth output active");
  b_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.pairBSelect |-> !serial_out_second)                                // [R14]
    else $error("second output active");
  bus_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    readStrobe_n |-> parallelBusOe_n == 16'hFFFF)                            // [R13]
    else $error("bus driven without read");
  range_a: assert property (@(posedge clk) disable iff (!rst_n)
    !softMode |-> mode.rangeWide == !pins.rangePinIn && rangePinOe_n)        // [R11]
    else $error("range pin misread");
  par_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.interfaceSelect |-> ##1 state == AOPM_IDLE || $past(state) == AOPM_SHIFT) // [R10]
    else $error("serial shift in parallel mode");

  // Parallel bus drive follows strobe, select and interface pins
  bus_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pins.interfaceSelect && !readStrobe_n && !chipSelect_n) |-> parallelBusOe_n == 16'h0000) // [R13]
    else $error("bus not driven during read");
  cs_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    chipSelect_n |-> parallelBusOe_n == 16'hFFFF)                            // [R13]
    else $error("bus driven without select");
  ser_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    pins.interfaceSelect |-> parallelBusOe_n == 16'hFFFF)                    // [R10]
    else $error("bus driven in serial mode");
  par_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pins.interfaceSelect |-> {serial_out_first, serial_out_second,
                               serial_out_third, serial_out_fourth} == 4'h0) // [R10]
    else $error("serial output active in parallel mode");
  par_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
    (busEnable && fifoValid && state == AOPM_IDLE) |=> outWord == $past(extended)) // [R13]
    else $error("parallel word not fetched");

  // Serial routing; a word leaves on exactly one lane
  lane_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({serial_out_first, serial_out_second, serial_out_third, serial_out_fourth})) // [R6]
    else $error("word on several lanes");
  first_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode.serialMode && (pairSel == 2'b00 || (pairSel == 2'b10 && !pins.pairCdOutputSelect)))
    |-> serial_out_first == serialBit)                                       // [R6]
    else $error("first output misrouted");
  second_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode.serialMode && pins.pairBSelect &&
     (pairSel == 2'b01 || (pairSel == 2'b11 && !pins.pairCdOutputSelect)))
    |-> serial_out_second == serialBit)                                      // [R7]
    else $error("second output misrouted");
  cd_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode.serialMode && pins.pairCdOutputSelect && pairSel[1])
    |-> ((pairSel[0] ? serial_out_fourth : serial_out_third) == serialBit))  // [R8]
    else $error("third or fourth output misrouted");
  b_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode.serialMode && !pins.pairBSelect && pairSel == 2'b01)
    |-> serial_out_first == serialBit)                                       // [R14]
    else $error("pair B lost with second output off");
  all_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode.serialMode && !pins.pairBSelect && !pins.pairCdOutputSelect)
    |-> serial_out_first == serialBit)                                       // [R14]
    else $error("single lane mode misrouted");

  // Serial word steps: load when idle, shift per enable, idle after bit 15
  sequence shiftStartSeq;
    state == AOPM_IDLE && mode.serialMode && fifoValid;
  endsequence
  sequence shiftLoadSeq;
    state == AOPM_SHIFT && bitCount == 5'h00;
  endsequence
  sequence shiftLastSeq;
    state == AOPM_SHIFT && bitCount == `AOPM_SHIFT_BITS && serialShiftClk;
  endsequence
  word_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    shiftStartSeq |=> shiftLoadSeq)                                          // [R10]
    else $error("serial word not loaded");
  word_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    shiftLastSeq |=> state == AOPM_IDLE)
    else $error("serial word overran");
  shift_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == AOPM_SHIFT && serialShiftClk) |=> shiftReg == {$past(shiftReg[14:0]), 1'b0})
    else $error("serial shift step wrong");

  // Range pin and conversion clock
  range_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (softMode && configWord[`AOPM_BIT_CLKOUT] && !configWord[`AOPM_BIT_EXTCLK])
    |-> !rangePinOe_n)                                                       // [R12]
    else $error("clock output not driven");
  ext_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (softMode && configWord[`AOPM_BIT_EXTCLK])
    |-> (convClock == pins.rangePinIn) && rangePinOe_n)                      // [R12]
    else $error("external clock not taken");
  hw_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    !softMode |-> (convClock == internalConvClock) && rangePinOe_n)          // [R11]
    else $error("range pin used as clock");

  // Register port and buffer fill side
  rd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !regRead |=> regRdData == 32'h0000_0000)
    else $error("read data without read");
  cfg_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (regRead && regAddr == `AOPM_REG_CONFIG) |=> regRdData == $past(configWord)) // [R9]
    else $error("configuration read wrong");
  full_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    fifoLevel == 4'h8 |-> !resultReady)
    else $error("result taken while full");
  level_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    fifoLevel <= 4'h8)
    else $error("buffer level past depth");
endmodule

// ==== aopm_host_model.sv ====
`timescale 1ns/1ns
module aopm_host_model (
  // Clock
  input  wire logic              clk,
  // Serial lanes, first in bit 0
  input  wire logic [3:0]        lanes,
  // Host strobes
  output logic                   readStrobe_n,
  output logic                   chipSelect_n,
  output logic                   serialShiftClk,
  // Captured serial words
  output logic      [3:0][15:0]  shiftWord
);
  initial begin
    readStrobe_n = 1'b1;
    chipSelect_n = 1'b1;
    serialShiftClk = 1'b0;
    shiftWord = '0;
  end
  // One cycle low per word, since every low cycle pops a word
  task automatic read_word();
    @(posedge clk);
    readStrobe_n <= 1'b0;
    chipSelect_n <= 1'b0;
    @(posedge clk);
    readStrobe_n <= 1'b1;
    chipSelect_n <= 1'b1;
  endtask
  task automatic shift_word();
    @(posedge clk);
    serialShiftClk <= 1'b1;
    repeat (16) @(posedge clk);
    serialShiftClk <= 1'b0;
  endtask
  // Bits land MSB first, one per enabled edge
  always @(posedge clk) begin
    if (serialShiftClk) begin
      for (int i = 0; i < 4; i++) begin
        shiftWord[i] <= {shiftWord[i][14:0], lanes[i]};
      end
    end
  end
endmodule

// ==== aopm_top_tb.sv ====
`timescale 1ns/1ns
`include "aopm_map.svh"
module aopm_top_tb
  import aopm_pkg::*;
;
  logic              clk, rst_n, regWrite, regRead, resultValid, resultReady;
  logic              readStrobe_n, chipSelect_n, serialShiftClk, internalConvClock;
  logic              rangePinOut, rangePinOe_n, convClock;
  aopm_pins_type     pins;
  aopm_mode_type     mode;
  logic [1:0]        resolution;
  logic [3:0]        regAddr, lanes;
  logic [31:0]       regWrData, regRdData, rd;
  logic [2:0]        resultChannel;
  logic [15:0]       resultData, parallelBusOut, parallelBusOe_n;
  logic [3:0][15:0]  shiftWord;
  logic [15:0]       signExp [3];
  logic [7:0]        serCase [9];
  int                nFail, totalChecks, cycles;

  aopm_top DUT (.clk(clk), .rst_n(rst_n), .pins(pins), .resolution(resolution),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .resultValid(resultValid), .resultReady(resultReady),
    .resultChannel(resultChannel), .resultData(resultData), .readStrobe_n(readStrobe_n),
    .chipSelect_n(chipSelect_n), .parallelBusOut(parallelBusOut),
    .parallelBusOe_n(parallelBusOe_n), .serialShiftClk(serialShiftClk),
    .serial_out_first(lanes[0]), .serial_out_second(lanes[1]),
    .serial_out_third(lanes[2]), .serial_out_fourth(lanes[3]),
    .internalConvClock(internalConvClock), .rangePinOut(rangePinOut),
    .rangePinOe_n(rangePinOe_n), .convClock(convClock), .mode(mode));
  aopm_host_model host (.clk(clk), .lanes(lanes), .readStrobe_n(readStrobe_n),
    .chipSelect_n(chipSelect_n), .serialShiftClk(serialShiftClk), .shiftWord(shiftWord));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, the full run needs well under a thousand cycles
  always @(posedge clk) begin
    internalConvClock <= ~internalConvClock;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nFail++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic push(input logic [2:0] ch, input logic [15:0] d);
    @(posedge clk);
    resultValid <= 1'b1;
    resultChannel <= ch;
    resultData <= d;
    @(posedge clk);
    resultValid <= 1'b0;
  endtask
  task automatic par_read(input logic [15:0] exp);
    fork
      host.read_word();
      begin
        @(posedge clk);
        #1 check(parallelBusOe_n, 32'h0000_0000);
      end
    join
    #1 check(parallelBusOe_n, 32'h0000_FFFF);
    repeat (2) @(posedge clk);
    #1 check(parallelBusOut, exp);
  endtask
  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    pins = '0;
    resolution = `AOPM_RES_16;
    {regAddr, regWrData, regWrite, regRead} = '0;
    {resultValid, resultChannel, resultData} = '0;
    internalConvClock = 1'b0;
    {nFail, totalChecks, cycles} = '0;
    signExp = '{16'hFA5C, 16'h1A5C, 16'h5A5C};
    // Case byte: B select, CD select, channel, lane
    serCase = '{8'hC0, 8'hC9, 8'hD2, 8'hDB, 8'h90, 8'h99, 8'h08, 8'h18, 8'h48};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(`AOPM_REG_CONFIG, rd);
    check(rd, `AOPM_CONFIG_RESET);
    pins.interfaceSelect <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      pins.refBufferDisablePin <= v[0];
      pins.rangePinIn <= v[0];
      @(posedge clk);
      #1 check(mode.refBuffersOn, !v[0]);
      check(mode.rangeWide, !v[0]);
      check(mode.serialMode, 1'b1);
    end
    pins.interfaceSelect <= 1'b0;
    pins.configSourceSelect <= 1'b1;
    reg_write(`AOPM_REG_CONFIG, 32'h0000_4000);
    check(mode.refBuffersOn, 1'b1);
    check(mode.serialMode, 1'b0);
    reg_write(`AOPM_REG_STATUS, 32'hFFFF_FFFF);
    reg_read(`AOPM_REG_CONFIG, rd);
    check(rd, 32'h0000_4000);
    reg_read(`AOPM_REG_STATUS, rd);
    check(rd, 32'h0000_0010);
    reg_read(4'hF, rd);
    check(rd, 32'h0000_0000);
    reg_write(`AOPM_REG_CONFIG, 32'h1000_0000);
    check(mode.convClockOutputEnable, 1'b1);
    check(rangePinOe_n, 1'b0);
    check(rangePinOut, internalConvClock);
    reg_write(`AOPM_REG_CONFIG, 32'h2000_0000);
    check(mode.extConvClockSelect, 1'b1);
    check(rangePinOe_n, 1'b1);
    check(convClock, pins.rangePinIn);
    reg_write(`AOPM_REG_CONFIG, 32'h0000_0000);
    check(mode.refBuffersOn, 1'b0);
    pins.configSourceSelect <= 1'b0;
    test_end("modes");
    for (int i = 0; i < 8; i++) push(i[2:0], 16'hA000 + 16'(i));
    #1 check(resultReady, 1'b0);
    reg_read(`AOPM_REG_LEVEL, rd);
    check(rd, 32'h0000_0008);
    for (int i = 0; i < 8; i++) par_read(16'hA000 + 16'(i));
    reg_read(`AOPM_REG_RESULT, rd);
    check(rd, 32'h0000_A007);
    reg_read(`AOPM_REG_LEVEL, rd);
    check(rd, 32'h0000_0000);
    test_end("fifo");
    for (int r = 0; r < 3; r++) begin
      resolution <= r[1:0];
      push(3'h1, 16'h5A5C);
      par_read(signExp[r]);
    end
    resolution <= `AOPM_RES_16;
    test_end("sign");
    pins.interfaceSelect <= 1'b1;
    foreach (serCase[k]) begin
      pins.pairBSelect <= serCase[k][7];
      pins.pairCdOutputSelect <= serCase[k][6];
      push(serCase[k][4:2], 16'hB2C0 + 16'(serCase[k][4:2]));
      repeat (3) @(posedge clk);
      host.shift_word();
      @(posedge clk);
      for (int n = 0; n < 4; n++) begin
        check(shiftWord[n], (n == serCase[k][1:0]) ? 16'hB2C0 + 16'(serCase[k][4:2]) : 0);
      end
    end
    test_end("serial");
    wrap_up();
  end
endmodule
